/* File: art_pkg.sv */
package art_pkg;
  // ==========================================================
  // Register map (byte-wide registers, byte addresses)
  localparam logic [7:0] ART_TIMER_CTRL_STATUS   = 8'h0D;
  localparam logic [7:0] ART_COUNTER_HIGH        = 8'h0E;
  localparam logic [7:0] ART_COUNTER_LOW         = 8'h0F;
  localparam logic [7:0] ART_RELOAD_HIGH         = 8'h10;
  localparam logic [7:0] ART_RELOAD_LOW          = 8'h11;
  localparam logic [7:0] ART_OUTPUT_CONTROL      = 8'h12;
  localparam logic [7:0] ART_CHANNEL_CTRL_STATUS = 8'h13;
  localparam logic [7:0] ART_DUTY_HIGH           = 8'h17;
  localparam logic [7:0] ART_DUTY_LOW            = 8'h18;

  // ==========================================================
  // Field positions
  localparam int ART_CMP_IE_BIT   = 0;
  localparam int ART_OVF_IE_BIT   = 1;
  localparam int ART_OVF_BIT      = 2;
  localparam int ART_CK_LO_BIT    = 3;
  localparam int ART_CK_HI_BIT    = 4;
  localparam int ART_CMPF_BIT     = 0;
  localparam int ART_POL_BIT      = 1;
  localparam int ART_PIN_EN_BIT   = 0;

  // ==========================================================
  // Reset values and timing
  localparam logic [7:0]  ART_REG_RESET   = 8'h00;
  localparam logic [11:0] ART_CNT_RESET   = 12'h000;
  localparam logic [11:0] ART_CNT_MAX     = 12'hFFF;
  localparam int          ART_SLOW_DIV    = 32;

  // ==========================================================
  // Counter clock select
  localparam logic [1:0] ART_CK_OFF  = 2'h0;
  localparam logic [1:0] ART_CK_TICK = 2'h1;
  localparam logic [1:0] ART_CK_CPU  = 2'h2;
endpackage : art_pkg

/* File: art_timer.sv */
// Contract
// - Slow mode divides counter clock by 32
// - Wait mode leaves timer fully unchanged
// - Halt stops; active-halt stops except tick+ovf_ie
// - Only overflow on tick wakes active-halt
// - Separate overflow and compare request lines
// - Request needs flag, enable, global mask clear
// - Clock select bits 4:3, reset clears
// - Overflow flag set on FFF to reload
// - Status read clears overflow; writes cannot
// - Overflow flag holds one counter cycle
// - Compare enable masks request, not flag
// - 12-bit counter runs, resets zero, read-only
// - Overflow reloads counter with reload value
// - Pin enable picks PWM or compare target
// - Polarity bit 1 inverts output, resets clear
// - Compare flag on match; channel read clears
// - Pin enable off releases pin to GPIO
// - Output high on overflow, low on match
// - PWM duty shadow loads only on overflow
// - High byte write suspends compare until low
// - Zero duty value disables compare matches
`timescale 1ns/1ns
module art_timer
  import art_pkg::*;
#(
  parameter int CNT_W = 12
) (
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic [7:0]       addr,
  input  wire logic [7:0]       wdata,
  input  wire logic             wr_stb,
  input  wire logic             rd_stb,
  output logic      [7:0]       rdata,
  input  wire logic             tick_clock,
  input  wire logic             slow_mode,
  input  wire logic             halt_mode,
  input  wire logic             active_halt_mode,
  input  wire logic             global_irq_mask,
  output logic                  overflow_irq,
  output logic                  compare_irq,
  output logic                  wakeup_req,
  output logic                  pwm_out,
  output logic                  pwm_out_oe
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0]       rdata;
    logic [1:0]       clk_sel;
    logic             overflow_flag;
    logic             overflow_irq_en;
    logic             compare_irq_en;
    logic             pwm_pin_enable;
    logic             pwm_polarity;
    logic             compare_flag;
    logic [CNT_W-1:0] up_counter;
    logic [CNT_W-1:0] reload_value;
    logic [CNT_W-1:0] duty_value;
    logic [CNT_W-1:0] duty_shadow;
    logic             cmp_locked;
    logic [4:0]       slow_cnt;
    logic             ovf_hold;
    logic             pwm_level;
    logic             overflow_irq;
    logic             compare_irq;
    logic             wakeup_req;
    logic             pwm_out;
    logic             pwm_out_oe;
  } art_state_t;

  art_state_t st_r;
  art_state_t st_nxt;

  function automatic logic [7:0] art_hi(input logic [CNT_W-1:0] v);
    art_hi = {4'h0, v[CNT_W-1:8]};
  endfunction : art_hi

  logic             src_en;
  logic             run_ok;
  logic             cnt_en;
  logic             at_max;
  logic             cmp_hit;
  logic [CNT_W-1:0] cmp_target;

  always_comb begin
    st_nxt = st_r;

    // ==========================================================
    // Counter clock: select, halt gating, slow divider
    case (st_r.clk_sel)
      ART_CK_TICK: src_en = tick_clock;
      ART_CK_CPU:  src_en = 1'b1;
      default:     src_en = 1'b0;
    endcase
    // Wait mode has no input here at all, so it cannot disturb the timer
    run_ok = !halt_mode &&
             (!active_halt_mode ||
              (st_r.clk_sel == ART_CK_TICK && st_r.overflow_irq_en));
    if (slow_mode && src_en && run_ok) begin
      st_nxt.slow_cnt = st_r.slow_cnt + 5'h01;
    end
    cnt_en = src_en && run_ok &&
             (!slow_mode || st_r.slow_cnt == 5'(ART_SLOW_DIV - 1));
    at_max = (st_r.up_counter == ART_CNT_MAX);

    // ==========================================================
    // Counting, reload and compare
    cmp_target = st_r.pwm_pin_enable ? st_r.duty_shadow
                                     : st_r.duty_value;
    cmp_hit = cnt_en && !st_r.cmp_locked &&
              cmp_target != ART_CNT_RESET &&
              st_r.up_counter == cmp_target;
    if (cnt_en) begin
      // Flag spans exactly one counter clock, then drops on next count enable
      st_nxt.ovf_hold = at_max;
      if (st_r.ovf_hold && !at_max) begin
        st_nxt.overflow_flag = 1'b0;
      end
      if (at_max) begin
        st_nxt.up_counter  = st_r.reload_value;
        st_nxt.duty_shadow = st_r.duty_value;
        st_nxt.pwm_level   = 1'b1;
      end else begin
        st_nxt.up_counter = st_r.up_counter + 12'h001;
      end
      if (cmp_hit && !at_max) begin
        st_nxt.pwm_level = 1'b0;
      end
    end

    // ==========================================================
    // Register reads; read side effects clear flags
    st_nxt.rdata = ART_REG_RESET;
    if (rd_stb) begin
      case (addr)
        ART_TIMER_CTRL_STATUS: begin
          st_nxt.rdata = {3'h0, st_r.clk_sel, st_r.overflow_flag,
                          st_r.overflow_irq_en, st_r.compare_irq_en};
          st_nxt.overflow_flag = 1'b0;
        end
        ART_COUNTER_HIGH: st_nxt.rdata = art_hi(st_r.up_counter);
        ART_COUNTER_LOW:  st_nxt.rdata = st_r.up_counter[7:0];
        ART_RELOAD_HIGH:  st_nxt.rdata = art_hi(st_r.reload_value);
        ART_RELOAD_LOW:   st_nxt.rdata = st_r.reload_value[7:0];
        ART_OUTPUT_CONTROL: st_nxt.rdata = {7'h00, st_r.pwm_pin_enable};
        ART_CHANNEL_CTRL_STATUS: begin
          st_nxt.rdata = {6'h00, st_r.pwm_polarity, st_r.compare_flag};
          st_nxt.compare_flag = 1'b0;
        end
        ART_DUTY_HIGH: st_nxt.rdata = art_hi(st_r.duty_value);
        ART_DUTY_LOW:  st_nxt.rdata = st_r.duty_value[7:0];
        default:       st_nxt.rdata = ART_REG_RESET;
      endcase
    end

    // ==========================================================
    // Register writes; counter and flags are not writable
    if (wr_stb) begin
      case (addr)
        ART_TIMER_CTRL_STATUS: begin
          st_nxt.clk_sel = wdata[ART_CK_HI_BIT:ART_CK_LO_BIT];
          st_nxt.overflow_irq_en = wdata[ART_OVF_IE_BIT];
          st_nxt.compare_irq_en  = wdata[ART_CMP_IE_BIT];
        end
        ART_RELOAD_HIGH: st_nxt.reload_value[CNT_W-1:8] = wdata[3:0];
        ART_RELOAD_LOW:  st_nxt.reload_value[7:0] = wdata;
        ART_OUTPUT_CONTROL: st_nxt.pwm_pin_enable = wdata[ART_PIN_EN_BIT];
        ART_CHANNEL_CTRL_STATUS: st_nxt.pwm_polarity = wdata[ART_POL_BIT];
        ART_DUTY_HIGH: begin
          // Software must write high first; compare waits for low
          st_nxt.duty_value[CNT_W-1:8] = wdata[3:0];
          st_nxt.cmp_locked = 1'b1;
        end
        ART_DUTY_LOW: begin
          st_nxt.duty_value[7:0] = wdata;
          st_nxt.cmp_locked = 1'b0;
        end
        default: ;
      endcase
    end

    // ==========================================================
    // Hardware sets win over a same-cycle read clear
    if (cnt_en && at_max) begin
      st_nxt.overflow_flag = 1'b1;
    end
    if (cmp_hit) begin
      st_nxt.compare_flag = 1'b1;
    end

    // ==========================================================
    // Requests and pin, all registered
    st_nxt.overflow_irq = st_nxt.overflow_flag && st_nxt.overflow_irq_en &&
                          !global_irq_mask;
    st_nxt.compare_irq  = st_nxt.compare_flag && st_nxt.compare_irq_en &&
                          !global_irq_mask;
    // Compare never wakes; overflow wakes only on tick source
    st_nxt.wakeup_req = st_nxt.overflow_irq &&
                        st_nxt.clk_sel == ART_CK_TICK;
    st_nxt.pwm_out    = st_nxt.pwm_pin_enable &&
                        (st_nxt.pwm_level ^ st_nxt.pwm_polarity);
    st_nxt.pwm_out_oe = st_nxt.pwm_pin_enable;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata        = st_r.rdata;
  assign overflow_irq = st_r.overflow_irq;
  assign compare_irq  = st_r.compare_irq;
  assign wakeup_req   = st_r.wakeup_req;
  assign pwm_out      = st_r.pwm_out;
  assign pwm_out_oe   = st_r.pwm_out_oe;

endmodule : art_timer

/* File: art_timer_assertions.sv */
`timescale 1ns/1ns
module art_timer_assertions
  import art_pkg::*;
(
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [7:0] rdata,
  input wire logic       global_irq_mask,
  input wire logic       overflow_irq,
  input wire logic       compare_irq,
  input wire logic       wakeup_req,
  input wire logic       pwm_out,
  input wire logic       pwm_out_oe
);
  // ==========
  // Port checks
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  AST_OVF_MASK: assert property (overflow_irq |-> !$past(global_irq_mask))
    else $error("overflow request while masked");
  AST_CMP_MASK: assert property (compare_irq |-> !$past(global_irq_mask))
    else $error("compare request while masked");
  // Wake is registered alongside the request, in the same cycle
  AST_WAKE_OVF: assert property (wakeup_req |->
    overflow_irq || $past(overflow_irq))
    else $error("wake without overflow request");
  AST_PIN_IDLE: assert property (!pwm_out_oe |-> !pwm_out)
    else $error("pwm level while pin released");
  AST_PIN_EN: assert property (wr_stb && addr == ART_OUTPUT_CONTROL |=> ##1
    pwm_out_oe == $past(wdata[ART_PIN_EN_BIT], 2))
    else $error("pin enable not taken from write");
  AST_CNT_RSVD: assert property (rd_stb && addr == ART_COUNTER_HIGH |=>
    rdata[7:4] == 4'h0)
    else $error("counter high reserved bits set");
  AST_CSR_RSVD: assert property (
    rd_stb && addr == ART_TIMER_CTRL_STATUS |=> rdata[7:5] == 3'h0)
    else $error("status reserved bits set");
  AST_CH_RSVD: assert property (
    rd_stb && addr == ART_CHANNEL_CTRL_STATUS |=> rdata[7:2] == 6'h00)
    else $error("channel reserved bits set");
endmodule : art_timer_assertions

bind art_timer art_timer_assertions i_art_timer_assertions (.mclk, .srst,
  .addr, .wdata, .wr_stb, .rd_stb, .rdata, .global_irq_mask, .overflow_irq,
  .compare_irq, .wakeup_req, .pwm_out, .pwm_out_oe);

/* File: art_pin_model.sv */
`timescale 1ns/1ns
module art_pin_model (
  input  wire logic drive,
  input  wire logic level,
  output logic      pin
);
  // ==========
  // Pad with a pull-up, so a released pin never shows a stale level
  assign pin = drive ? level : 1'b1;
endmodule : art_pin_model

/* File: test_autoreload_timer_pwm.sv */
`timescale 1ns/1ns
module test_autoreload_timer_pwm;
  import art_pkg::*;
  // ==========
  // Bench
  logic       mclk, srst, wr_stb, rd_stb, tick_clock, slow_mode, halt_mode;
  logic       active_halt_mode, global_irq_mask, overflow_irq, compare_irq;
  logic       wakeup_req, pwm_out, pwm_out_oe, pin;
  logic [7:0] addr, wdata, rdata, v, w;
  int         n_errors, n_compared, n;

  art_timer i_art_timer (.mclk, .srst, .addr, .wdata, .wr_stb, .rd_stb,
    .rdata, .tick_clock, .slow_mode, .halt_mode, .active_halt_mode,
    .global_irq_mask, .overflow_irq, .compare_irq, .wakeup_req, .pwm_out,
    .pwm_out_oe);
  art_pin_model i_art_pin_model (.drive(pwm_out_oe), .level(pwm_out), .pin);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // One-cycle tick every other clock keeps the tick-driven runs short
  always @(posedge mclk) tick_clock <= ~tick_clock;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask : rd

  task automatic wait_for(const ref logic s, input int lim);
    for (n = 0; n < lim && s !== 1'b1; n++) @(negedge mclk);
    check(s, 1'b1);
    if (s !== 1'b1) stop_test();
  endtask : wait_for

  task automatic count_high(input logic [15:0] exp);
    n = 0;
    repeat (32) begin
      @(negedge mclk);
      n += int'(pin);
    end
    check(16'(n), exp);
  endtask : count_high

  task automatic t_reset;
    logic [7:0] map [10] = '{8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12,
                             8'h13, 8'h14, 8'h17, 8'h18};
    foreach (map[i]) begin
      rd(map[i], v);
      check(v, ART_REG_RESET);
    end
  endtask : t_reset

  task automatic t_overflow;
    wr(ART_RELOAD_HIGH, 8'h0F);
    wr(ART_RELOAD_LOW, 8'hF0);
    wr(ART_TIMER_CTRL_STATUS, 8'h12);
    wait_for(overflow_irq, 5000);
    rd(ART_COUNTER_HIGH, v);
    check(v, 8'h0F);
    rd(ART_TIMER_CTRL_STATUS, v);
    check(v & 8'hFB, 8'h12);
    global_irq_mask <= 1'b1;
    repeat (40) @(negedge mclk);
    check(overflow_irq, 1'b0);
    global_irq_mask <= 1'b0;
  endtask : t_overflow

  task automatic t_pwm;
    wr(ART_DUTY_HIGH, 8'h0F);
    wr(ART_DUTY_LOW, 8'hF4);
    wr(ART_OUTPUT_CONTROL, 8'h01);
    repeat (40) @(negedge mclk);
    // Level stands while counter shows FF0..FF4, then drops
    count_high(16'h000A);
    rd(ART_CHANNEL_CTRL_STATUS, v);
    check(v, 8'h01);
    wr(ART_CHANNEL_CTRL_STATUS, 8'h02);
    repeat (40) @(negedge mclk);
    count_high(16'h0016);
    wr(ART_OUTPUT_CONTROL, 8'h00);
    repeat (4) @(negedge mclk);
    check({pwm_out_oe, pin}, 2'b01);
    wr(ART_TIMER_CTRL_STATUS, 8'h11);
    wait_for(compare_irq, 40);
  endtask : t_pwm

  task automatic t_slow;
    wr(ART_TIMER_CTRL_STATUS, 8'h12);
    slow_mode <= 1'b1;
    // First pulse may straddle the mode change, so skip it
    wait_for(overflow_irq, 600);
    for (n = 0; n < 100 && overflow_irq === 1'b1; n++) @(negedge mclk);
    for (n = 0; n < 1000 && overflow_irq !== 1'b1; n++) @(negedge mclk);
    for (n = 0; n < 100 && overflow_irq === 1'b1; n++) @(negedge mclk);
    check(16'(n), 16'h0020);
    for (n = 0; n < 1000 && overflow_irq !== 1'b1; n++) @(negedge mclk);
    check(16'(n), 16'h01E0);
    slow_mode <= 1'b0;
  endtask : t_slow

  task automatic t_halt;
    for (int m = 0; m < 2; m++) begin
      halt_mode        <= (m == 0);
      active_halt_mode <= (m == 1);
      repeat (3) @(posedge mclk);
      rd(ART_COUNTER_LOW, v);
      repeat (20) @(posedge mclk);
      rd(ART_COUNTER_LOW, w);
      check(w, v);
    end
    active_halt_mode <= 1'b0;
  endtask : t_halt

  task automatic t_tick;
    wr(ART_TIMER_CTRL_STATUS, 8'h0A);
    wait_for(wakeup_req, 200);
    active_halt_mode <= 1'b1;
    rd(ART_TIMER_CTRL_STATUS, v);
    repeat (4) @(negedge mclk);
    wait_for(wakeup_req, 200);
  endtask : t_tick

  initial begin
    n_errors = 0;
    n_compared = 0;
    {srst, addr, wdata, wr_stb, rd_stb} = {1'b1, 18'h0};
    {tick_clock, slow_mode, halt_mode} = 3'h0;
    {active_halt_mode, global_irq_mask} = 2'h0;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    t_reset();
    t_overflow();
    t_pwm();
    t_slow();
    t_halt();
    t_tick();
    stop_test();
  end
endmodule : test_autoreload_timer_pwm
